// ==== logic/lpm_params.svh ====
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// Clock and timing figures.
`define LPM_CLK_HZ        50000000
`define LPM_PUMP_HZ       850000
`define LPM_PUMP_HALF     (`LPM_CLK_HZ / (2 * `LPM_PUMP_HZ))
`define LPM_PUMP_GAP      2
`define LPM_DROP_SLOW_US  150000
`define LPM_DROP_FAST_US  2000
`define LPM_SOFT_US       125
`define LPM_US2CYC(us)    ((us) * (`LPM_CLK_HZ / 1000000))
`define LPM_SS_TOP        8'hFF

// Serial port.
`define LPM_I2C_ADDR      7'h1B
`define LPM_NBYTES        2'h3

// Bus register byte offsets and reset values.
`define LPM_REG_CTRL      8'h00
`define LPM_REG_STATUS    8'h04
`define LPM_REG_DAC       8'h08
`define LPM_CTRL_RST      1'h0

// Option byte fields.
`define LPM_C_AUX_MSB     1
`define LPM_C_FAST        2
`define LPM_C_GPO_MODE    3
`define LPM_C_GPO_LEVEL   4
`define LPM_C_FORCE_LSB   5
`define LPM_C_FORCE_MSB   6

// Pump switch vector bit positions.
`define LPM_SW_WEAK       0
`define LPM_SW_BYPASS     1
`define LPM_SW_SERIES     2
`define LPM_SW_STACK      3
`define LPM_SW_C1CHG      4
`define LPM_SW_C2CHG      5

// Synchroniser vector layout.
`define LPM_SY_SDA        0
`define LPM_SY_SCL        1
`define LPM_SY_FLS        2
`define LPM_SY_MAIN       3
`define LPM_SY_FLASH      9
`define LPM_SY_W          11
`define LPM_MAIN_MAX      6
`define LPM_FLASH_MAX     2

`endif

// ==== logic/lpm_pkg.sv ====
`include "lpm_params.svh"

package lpm_pkg;

	typedef enum logic [1:0] {
		mode_unity  = 2'b00,
		mode_half   = 2'b01,
		mode_double = 2'b10
	} lpm_mode_e;

	typedef enum logic [2:0] {
		rx_idle     = 3'b000,
		rx_addr     = 3'b001,
		rx_ack_addr = 3'b010,
		rx_data     = 3'b011,
		rx_ack_data = 3'b100
	} lpm_rx_e;

	typedef struct packed {
		logic       scl_d;
		logic       sda_d;
		lpm_rx_e    st;
		logic [7:0] sh;
		logic [3:0] bits;
		logic [1:0] nbyte;
		logic [7:0] stg_a;
		logic [7:0] stg_b;
		logic [7:0] ha;
		logic [7:0] hb;
		logic [7:0] hc;
		logic       pend;
		logic       busy;
		logic       oe;
		logic       load;
	} lpm_rx_s;

	typedef struct packed {
		logic [`LPM_SY_W-1:0] sy1;
		logic [`LPM_SY_W-1:0] sy2;
		logic                 fls_d;
		lpm_mode_e            mode;
		logic [7:0]           dac_a;
		logic [7:0]           dac_b;
		logic [7:0]           dac_c;
		logic                 auto_off;
		logic [22:0]          drop_cnt;
		logic [12:0]          ss_cnt;
		logic [7:0]           ss_level;
		logic                 ss_act;
		logic [5:0]           pump_cnt;
		logic [1:0]           phase;
		logic [5:0]           sw;
		logic                 shdn;
		logic [7:0]           main_code;
		logic [5:0]           main_en;
		logic [3:0]           flash_code;
		logic [1:0]           flash_en;
		logic [1:0]           aux_code;
		logic                 aux_oe;
		logic                 ctrl_fast;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} lpm_top_s;

endpackage

// ==== logic/lpm_i2c_rx.sv ====
`timescale 1ns/100ps
`include "lpm_params.svh"

module lpm_i2c_rx (
	// Clock, reset, enable.
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	// Synchronised bus lines.
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe,
	// Held bytes and load strobe.
	output logic            load,
	output logic [7:0]      data_a,
	output logic [7:0]      data_b,
	output logic [7:0]      data_c
);
	import lpm_pkg::*;

	lpm_rx_s r_q;
	lpm_rx_s r_d;
	logic    rise;
	logic    fall;
	logic    start;
	logic    stop;

	assign rise   = scl & ~r_q.scl_d;
	assign fall   = ~scl & r_q.scl_d;
	assign start  = scl & r_q.scl_d & r_q.sda_d & ~sda;
	assign stop   = scl & r_q.scl_d & ~r_q.sda_d & sda;
	assign sda_oe = r_q.oe;
	assign load   = r_q.load;
	assign data_a = r_q.ha;
	assign data_b = r_q.hb;
	assign data_c = r_q.hc;

	// Everything is sampled on mclk edges with no minimum bus rate, so any
	// slow or paused serial clock is tolerated.
	always_comb begin
		r_d = r_q;
		if (clk_en) begin
			r_d.load = 1'b0;
			r_d.scl_d = scl;
			r_d.sda_d = sda;
			if (start) begin
				r_d.st = rx_addr;
				r_d.bits = 4'h0;
				r_d.nbyte = 2'h0;
				r_d.oe = 1'b0;
			end else if (stop) begin
				r_d.st = rx_idle;
				r_d.oe = 1'b0;
				// A stop in the middle of a fresh data set ends the frame but does not load the held bytes.
				if (r_q.pend && !r_q.busy) begin
					r_d.load = 1'b1;
					r_d.pend = 1'b0;
				end
			end else begin
				if (rise && (r_q.st == rx_addr || r_q.st == rx_data)) begin
					r_d.sh = {r_q.sh[6:0], sda};
					r_d.bits = r_q.bits + 4'h1;
				end
				unique case (r_q.st)
					rx_idle: begin
					end
					rx_addr: begin
						if (fall && r_q.bits == 4'h8) begin
							r_d.bits = 4'h0;
							if (r_q.sh == {`LPM_I2C_ADDR, 1'b0}) begin
								r_d.st = rx_ack_addr;
								r_d.oe = 1'b1;
								r_d.busy = 1'b1;
							end else begin
								r_d.st = rx_idle;
							end
						end
					end
					rx_ack_addr: begin
						if (fall) begin
							r_d.oe = 1'b0;
							r_d.st = rx_data;
						end
					end
					rx_data: begin
						if (fall && r_q.bits == 4'h8) begin
							r_d.bits = 4'h0;
							r_d.oe = 1'b1;
							r_d.st = rx_ack_data;
							unique case (r_q.nbyte)
								2'h0: r_d.stg_a = r_q.sh;
								2'h1: r_d.stg_b = r_q.sh;
								default: begin
									r_d.ha = r_q.stg_a;
									r_d.hb = r_q.stg_b;
									r_d.hc = r_q.sh;
									r_d.pend = 1'b1;
									r_d.busy = 1'b0;
								end
							endcase
						end
					end
					rx_ack_data: begin
						if (fall) begin
							r_d.oe = 1'b0;
							r_d.nbyte = r_q.nbyte + 2'h1;
							if (r_q.nbyte + 2'h1 == `LPM_NBYTES) begin
								r_d.st = rx_idle;
							end else begin
								r_d.st = rx_data;
							end
						end
					end
					default: r_d.st = rx_idle;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
endmodule

// ==== logic/lpm_ctrl.sv ====
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "lpm_params.svh"


module lpm_ctrl #(
	parameter bit TWO_FLASH     = 1'b0,
	parameter int DROP_SLOW_CYC = `LPM_US2CYC(`LPM_DROP_SLOW_US),
	parameter int DROP_FAST_CYC = `LPM_US2CYC(`LPM_DROP_FAST_US),
	parameter int SOFT_CYC      = `LPM_US2CYC(`LPM_SOFT_US)
) (
	// Clock, undervoltage lockout reset, enable.
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  clk_en,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Serial port pins.
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	// Flash select and dropout sense.
	input  wire logic                  flash_level_select,
	input  wire logic [5:0]            dropout_main,
	input  wire logic [1:0]            dropout_flash,
	// Charge pump control.
	output lpm_pkg::lpm_mode_e         pump_mode,
	output logic [1:0]                 pump_phase,
	output logic [5:0]                 pump_switch,
	output logic [7:0]                 soft_start_level,
	output logic                       shutdown,
	// Current source codes.
	output logic [7:0]                 main_code,
	output logic [5:0]                 main_en,
	output logic [3:0]                 flash_code,
	output logic [1:0]                 flash_en,
	output logic [1:0]                 aux_code,
	output logic                       aux_gpo_out,
	output logic                       aux_gpo_oe
);
	import lpm_pkg::*;

	localparam int MAIN_N  = TWO_FLASH ? 5 : `LPM_MAIN_MAX;
	localparam int FLASH_N = TWO_FLASH ? 2 : 1;
	localparam logic [12:0] SS_STEP = 13'(SOFT_CYC / 255);
	localparam logic [5:0] PH_HALF = 6'(`LPM_PUMP_HALF);
	localparam logic [5:0] PH_GAP = 6'(`LPM_PUMP_GAP);

	lpm_top_s   r_q;
	lpm_top_s   r_d;
	logic       rx_load;
	logic       rx_oe;
	logic [7:0] rx_a;
	logic [7:0] rx_b;
	logic [7:0] rx_c;
	logic [5:0] main_qual;
	logic [1:0] flash_qual;

	// Address decode shared by read and write paths.
	function automatic logic [1:0] reg_index(input logic [7:0] a);
		unique case (a)
			`LPM_REG_CTRL:   reg_index = 2'h1;
			`LPM_REG_STATUS: reg_index = 2'h2;
			`LPM_REG_DAC:    reg_index = 2'h3;
			default:         reg_index = 2'h0;
		endcase
	endfunction

	lpm_i2c_rx u_rx (
		.mclk   (mclk),
		.resetn (resetn),
		.clk_en (clk_en),
		.scl    (r_q.sy2[`LPM_SY_SCL]),
		.sda    (r_q.sy2[`LPM_SY_SDA]),
		.sda_oe (rx_oe),
		.load   (rx_load),
		.data_a (rx_a),
		.data_b (rx_b),
		.data_c (rx_c)
	);

	// The indicator has no sense input at all, so it cannot move the mode.
	generate
		for (genvar i = 0; i < `LPM_MAIN_MAX; i++) begin : g_main
			assign main_qual[i] = (i < MAIN_N) && (r_q.dac_a != 8'h00)
				&& r_q.sy2[`LPM_SY_MAIN + i];
		end
		for (genvar j = 0; j < `LPM_FLASH_MAX; j++) begin : g_flash
			assign flash_qual[j] = (j < FLASH_N) && (r_q.dac_b != 8'h00)
				&& r_q.sy2[`LPM_SY_FLASH + j];
		end
	endgenerate

	always_comb begin
		logic        fls;
		logic        fast;
		logic        hit_w;
		logic [1:0]  idx;
		logic [22:0] lim;
		logic [1:0]  force_m;
		logic        go_boost;
		fls = r_q.sy2[`LPM_SY_FLS];
		fast = 1'b0;
		hit_w = 1'b0;
		idx = reg_index(paddr);
		lim = 23'h000000;
		force_m = 2'h0;
		go_boost = 1'b0;
		r_d = r_q;
		if (clk_en) begin
			r_d.sy1 = {dropout_flash, dropout_main, flash_level_select,
				scl_in, sda_in};
			r_d.sy2 = r_q.sy1;
			r_d.fls_d = fls;

			// Register bus: answer one cycle into the access phase.
			if (psel && penable && !r_q.pready) begin
				r_d.pready = 1'b1;
				r_d.pslverr = (idx == 2'h0);
				unique case (idx)
					2'h1: r_d.prdata = {31'h0, r_q.ctrl_fast};
					2'h2: r_d.prdata = {26'h0, r_q.auto_off, fls,
						r_q.ss_act, r_q.shdn, r_q.mode};
					2'h3: r_d.prdata = {8'h00, r_q.dac_c, r_q.dac_b,
						r_q.dac_a};
					default: r_d.prdata = 32'h0;
				endcase
			end else begin
				r_d.pready = 1'b0;
				r_d.pslverr = 1'b0;
			end
			hit_w = psel && penable && r_q.pready && pwrite;
			if (hit_w && idx == 2'h1) begin
				r_d.ctrl_fast = pwdata[0];
			end

			fast = r_q.ctrl_fast || r_q.dac_c[`LPM_C_FAST] || fls;
			lim = fast ? 23'(DROP_FAST_CYC - 1)
				: 23'(DROP_SLOW_CYC - 1);
			force_m = r_q.dac_c[`LPM_C_FORCE_MSB:`LPM_C_FORCE_LSB];

			if (rx_load) begin
				r_d.dac_a = rx_a;
				r_d.dac_b = rx_b;
				r_d.dac_c = rx_c;
				r_d.drop_cnt = 23'h0;
				r_d.auto_off = 1'b0;
				r_d.mode = mode_unity;
				force_m = rx_c[`LPM_C_FORCE_MSB:`LPM_C_FORCE_LSB];
				if (force_m == 2'h1 || force_m == 2'h2) begin
					r_d.mode = lpm_mode_e'(force_m);
					r_d.auto_off = 1'b1;
					go_boost = 1'b1;
				end
			end else if (r_q.auto_off || r_q.shdn) begin
				r_d.drop_cnt = 23'h0;
			end else if (r_q.fls_d && !fls) begin
				r_d.mode = mode_unity;
				r_d.drop_cnt = 23'h0;
			end else if ((|main_qual) || (|flash_qual)) begin
				if (r_q.drop_cnt >= lim) begin
					r_d.drop_cnt = 23'h0;
					unique case (r_q.mode)
						mode_unity: begin
							r_d.mode = mode_half;
							go_boost = 1'b1;
						end
						mode_half: begin
							r_d.mode = mode_double;
							go_boost = 1'b1;
						end
						mode_double: r_d.mode = mode_double;
						default: r_d.mode = mode_unity;
					endcase
				end else begin
					r_d.drop_cnt = r_q.drop_cnt + 23'h1;
				end
			end else begin
				r_d.drop_cnt = 23'h0;
			end

			// Any all-zero set of codes shuts the pump down.
			r_d.shdn = (r_d.dac_a == 8'h00) && (r_d.dac_b == 8'h00)
				&& (r_d.dac_c[`LPM_C_AUX_MSB:0] == 2'h0);
			if (r_d.shdn) begin
				r_d.mode = mode_unity;
			end

			// Linear ramp of available pump current on boost entry.
			if (go_boost) begin
				r_d.ss_act = 1'b1;
				r_d.ss_level = 8'h00;
				r_d.ss_cnt = 13'h0;
			end else if (r_q.ss_act) begin
				if (r_q.ss_cnt >= SS_STEP - 13'h1) begin
					r_d.ss_cnt = 13'h0;
					r_d.ss_level = r_q.ss_level + 8'h01;
					r_d.ss_act = (r_q.ss_level + 8'h01) != `LPM_SS_TOP;
				end else begin
					r_d.ss_cnt = r_q.ss_cnt + 13'h1;
				end
			end
			if (r_d.mode == mode_unity) begin
				r_d.ss_act = 1'b0;
				r_d.ss_level = `LPM_SS_TOP;
			end

			// Two-phase clock, held off in unity mode, with a dead band after each
			// phase so the switches never conduct together.
			if (r_q.pump_cnt >= (PH_HALF << 1) - 6'h1) begin
				r_d.pump_cnt = 6'h0;
			end else begin
				r_d.pump_cnt = r_q.pump_cnt + 6'h1;
			end
			r_d.phase = 2'b00;
			if (r_d.mode != mode_unity) begin
				r_d.phase[0] = r_q.pump_cnt < PH_HALF - PH_GAP;
				r_d.phase[1] = (r_q.pump_cnt >= PH_HALF)
					&& (r_q.pump_cnt < (PH_HALF << 1) - PH_GAP);
			end
			r_d.sw = 6'h00;
			if (r_d.shdn) begin
				r_d.sw[`LPM_SW_WEAK] = 1'b1;
			end else begin
				unique case (r_d.mode)
					mode_unity: r_d.sw[`LPM_SW_BYPASS] = 1'b1;
					mode_half: begin
						r_d.sw[`LPM_SW_SERIES] = r_d.phase[0];
						r_d.sw[`LPM_SW_STACK] = r_d.phase[1];
					end
					mode_double: begin
						r_d.sw[`LPM_SW_C1CHG] = r_d.phase[0];
						r_d.sw[`LPM_SW_C2CHG] = r_d.phase[1];
					end
					default: r_d.sw = 6'h00;
				endcase
			end

			// Current source codes; a zero word turns the group off.
			r_d.main_code = r_q.dac_a;
			r_d.main_en = (r_q.dac_a != 8'h00)
				? 6'(({`LPM_MAIN_MAX{1'b1}}) >> (`LPM_MAIN_MAX - MAIN_N))
				: 6'h00;
			r_d.flash_code = fls ? r_q.dac_b[7:4]
				: r_q.dac_b[3:0];
			r_d.flash_en = (r_d.flash_code != 4'h0)
				? 2'(({`LPM_FLASH_MAX{1'b1}}) >> (`LPM_FLASH_MAX - FLASH_N))
				: 2'h0;
			if (r_q.dac_c[`LPM_C_GPO_MODE]) begin
				r_d.aux_code = 2'h0;
				r_d.aux_oe = !r_q.dac_c[`LPM_C_GPO_LEVEL];
			end else begin
				r_d.aux_code = r_q.dac_c[`LPM_C_AUX_MSB:0];
				r_d.aux_oe = 1'b0;
			end
		end
	end

	// Lockout holds everything at zero, which is also unity mode.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata           = r_q.prdata;
	assign pready           = r_q.pready;
	assign pslverr          = r_q.pslverr;
	assign sda_out          = 1'b0;
	assign sda_oe           = rx_oe;
	assign pump_mode        = r_q.mode;
	assign pump_phase       = r_q.phase;
	assign pump_switch      = r_q.sw;
	assign soft_start_level = r_q.ss_level;
	assign shutdown         = r_q.shdn;
	assign main_code        = r_q.main_code;
	assign main_en          = r_q.main_en;
	assign flash_code       = r_q.flash_code;
	assign flash_en         = r_q.flash_en;
	assign aux_code         = r_q.aux_code;
	assign aux_gpo_out      = 1'b0;
	assign aux_gpo_oe       = r_q.aux_oe;
endmodule

// ==== tb/lpm_ctrl_asserts.sv ====
`timescale 1ns/100ps
`include "lpm_params.svh"

module lpm_ctrl_asserts #(
	parameter int DROP_SLOW_CYC = 200,
	parameter int DROP_FAST_CYC = 50,
	parameter int SOFT_CYC      = 510
) (
	// Clock and lockout reset.
	input wire logic               mclk,
	input wire logic               resetn,
	// Pump outputs.
	input wire lpm_pkg::lpm_mode_e pump_mode,
	input wire logic [1:0]         pump_phase,
	input wire logic [5:0]         pump_switch,
	input wire logic [7:0]         soft_start_level,
	input wire logic               shutdown
);
	import lpm_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence boost_entry;
		$changed(pump_mode) && pump_mode != mode_unity;
	endsequence

	sequence phase1_end;
		$fell(pump_phase[0]);
	endsequence

	chk_start_unity: assert property (
		$rose(resetn) |-> pump_mode == mode_unity)
		else $error("mode not unity after reset release");
	chk_unity_idle: assert property (
		(pump_mode == mode_unity) [*3] |-> pump_phase == 2'b00)
		else $error("pump clock running in unity mode");
	chk_step_half: assert property (
		$changed(pump_mode) && $past(pump_mode) == mode_unity
		|-> pump_mode == mode_half)
		else $error("unity did not step to half boost");
	chk_step_double: assert property (
		$changed(pump_mode) && $past(pump_mode) == mode_half
		|-> pump_mode inside {mode_double, mode_unity})
		else $error("half boost left to a wrong mode");
	chk_double_sat: assert property (
		pump_mode == mode_double |=> pump_mode != mode_half)
		else $error("doubling mode stepped back to half");
	chk_phase_excl: assert property (
		pump_phase != 2'b11)
		else $error("pump phases overlap");
	chk_phase_gap: assert property (
		phase1_end |-> (!pump_phase[1]) [*2])
		else $error("no gap between pump phases");
	chk_half_series: assert property (
		pump_mode == mode_half && $stable(pump_mode)
		&& pump_phase != 2'b00
		|-> pump_switch[`LPM_SW_SERIES] == pump_phase[0]
		&& pump_switch[`LPM_SW_STACK] == pump_phase[1])
		else $error("half boost switch order wrong");
	chk_double_alt: assert property (
		pump_mode == mode_double && $stable(pump_mode)
		&& pump_phase != 2'b00
		|-> pump_switch[`LPM_SW_C1CHG] != pump_switch[`LPM_SW_C2CHG])
		else $error("doubling caps not charged alternately");
	chk_weak_only: assert property (
		shutdown [*2] |-> pump_switch == 6'h01)
		else $error("shutdown enables more than the weak switch");
	chk_soft_ramp: assert property (
		boost_entry |-> ##[0:3] soft_start_level < 8'h10)
		else $error("no soft start ramp on boost entry");
endmodule

bind lpm_ctrl lpm_ctrl_asserts #(
	.DROP_SLOW_CYC(DROP_SLOW_CYC),
	.DROP_FAST_CYC(DROP_FAST_CYC),
	.SOFT_CYC     (SOFT_CYC)
) lpm_ctrl_asserts_inst (
	.mclk, .resetn, .pump_mode, .pump_phase, .pump_switch,
	.soft_start_level, .shutdown
);

// ==== tb/lpm_i2c_host.sv ====
`timescale 1ns/100ps

module lpm_i2c_host (
	// Bus lines; a released line reads high through the pull-up.
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	localparam time QTR = 40ns;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// The clock stands high between frames; every frame ends in a stop.
	task automatic frame(input logic [7:0] b [4], input int n, output int acks);
		acks = 0;
		sda_drv = 1'b0;
		#QTR;
		for (int i = 0; i < n; i++) begin
			for (int k = 8; k >= 0; k--) begin
				scl = 1'b0;
				#QTR;
				sda_drv = (k == 0) ? 1'b1 : b[i][k-1];
				#QTR;
				scl = 1'b1;
				#QTR;
				if (k == 0 && sda === 1'b0) begin
					acks++;
				end
				#QTR;
			end
		end
		scl = 1'b0;
		#QTR;
		sda_drv = 1'b0;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_drv = 1'b1;
		#QTR;
	endtask
endmodule

// ==== tb/led_pump_mode_dac_control_tb.sv ====
`timescale 1ns/100ps

module led_pump_mode_dac_control_tb;
	import lpm_pkg::*;

	typedef struct packed {
		logic        err;
		logic [31:0] data;
	} lpm_exp_s;

	logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, main_code, soft_start_level, m;
	logic [31:0] pwdata, prdata, rng;
	logic        scl, sda_drv, sda_out, sda_oe, flash_level_select;
	logic        shutdown, aux_gpo_out, aux_gpo_oe;
	logic [5:0]  dropout_main, pump_switch, main_en;
	logic [1:0]  dropout_flash, pump_phase, flash_en, aux_code;
	logic [3:0]  flash_code;
	lpm_mode_e   pump_mode;
	lpm_exp_s    exp_q[$];
	lpm_exp_s    e;
	int          mismatches, checked;
	wire         sda_line = sda_drv & ~(sda_oe & ~sda_out);
	logic [7:0]  opts [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h18};

	lpm_ctrl #(.DROP_SLOW_CYC(200), .DROP_FAST_CYC(50), .SOFT_CYC(510))
	lpm_ctrl_inst (
		.mclk, .resetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda_line),
		.sda_out, .sda_oe, .flash_level_select, .dropout_main, .dropout_flash,
		.pump_mode, .pump_phase, .pump_switch, .soft_start_level, .shutdown,
		.main_code, .main_en, .flash_code, .flash_en, .aux_code, .aux_gpo_out,
		.aux_gpo_oe
	);

	lpm_i2c_host lpm_i2c_host_inst (.scl, .sda_drv, .sda(sda_line));

	always #10 mclk = ~mclk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [32:0] ex, got);
		checked++;
		if (got !== ex) begin
			$display("wrong value %s expected %h seen %h", nm, ex, got);
			mismatches++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic er);
		exp_q.push_back({er, d});
		apb(1'b0, a, 32'h0);
	endtask

	task automatic send(input logic [7:0] a, b, c, o, input int n, ea);
		int acks;
		lpm_i2c_host_inst.frame('{a, b, c, o}, n, acks);
		cmp("ack count", 33'(ea), 33'(acks));
		repeat (10) @(posedge mclk);
	endtask

	task automatic wait_mode(input lpm_mode_e md, input int lo, hi);
		int n;
		n = 0;
		while (pump_mode !== md && n <= hi) begin
			@(posedge mclk);
			n++;
		end
		cmp("step delay", 33'h1, 33'(n >= lo && n <= hi));
		if (n > hi) begin
			give_verdict();
		end
	endtask

	// The read checker takes the oldest expectation when a read completes.
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (exp_q.size() == 0) begin
				cmp("read queue", 33'h0, 33'h1);
			end else begin
				e = exp_q.pop_front();
				cmp("apb read", e, {pslverr, prdata});
			end
		end
	end

	initial begin
		#1ms;
		mismatches++;
		give_verdict();
	end

	initial begin
		{mclk, resetn, psel, penable, pwrite, flash_level_select} = '0;
		{paddr, pwdata, dropout_main, dropout_flash} = '0;
		rng = 32'h8;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(8'h00, 32'h0, 1'b0);
		rd(8'h04, 32'h4, 1'b0);
		rd(8'h08, 32'h0, 1'b0);
		rd(8'h0C, 32'h0, 1'b1);
		apb(1'b1, 8'h04, 32'hFF);
		rd(8'h04, 32'h4, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		rd(8'h00, 32'h1, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		rng = xs(rng);
		m = rng[7:0] | 8'h01;
		send(8'h36, m, 8'hA5, 8'h00, 4, 4);
		cmp("main code", 33'(m), 33'(main_code));
		cmp("main enables", 33'h3F, 33'(main_en));
		cmp("flash low", 33'h5, 33'(flash_code));
		cmp("shutdown", 33'h0, 33'(shutdown));
		rd(8'h08, {8'h00, 8'h00, 8'hA5, m}, 1'b0);
		flash_level_select <= 1'b1;
		repeat (6) @(posedge mclk);
		cmp("flash high", 33'hA, 33'(flash_code));
		dropout_flash <= 2'b01;
		wait_mode(mode_half, 48, 58);
		wait_mode(mode_double, 48, 58);
		repeat (150) @(posedge mclk);
		cmp("mode saturates", 33'(mode_double), 33'(pump_mode));
		{dropout_flash, flash_level_select} <= '0;
		repeat (6) @(posedge mclk);
		cmp("select fall", 33'(mode_unity), 33'(pump_mode));
		dropout_flash <= 2'b10;
		repeat (300) @(posedge mclk);
		cmp("absent channel", 33'(mode_unity), 33'(pump_mode));
		dropout_flash <= 2'b00;
		dropout_main <= 6'h20;
		wait_mode(mode_half, 198, 208);
		send(8'h36, m, 8'hA5, 8'h04, 4, 4);
		cmp("load unity", 33'(mode_unity), 33'(pump_mode));
		wait_mode(mode_half, 40, 46);
		dropout_main <= 6'h00;
		for (int i = 0; i < 6; i++) begin
			send(8'h36, m, 8'hA5, opts[i], 4, 4);
			cmp("aux code", 33'(i < 4 ? i : 0), 33'(aux_code));
			cmp("gpo drive", 33'(i == 4), 33'(aux_gpo_oe));
			cmp("gpo level", 33'h0, 33'(aux_gpo_out));
		end
		send(8'h36, m, 8'hA5, 8'h20, 4, 4);
		cmp("forced half", 33'(mode_half), 33'(pump_mode));
		dropout_main <= 6'h20;
		repeat (300) @(posedge mclk);
		cmp("auto suspended", 33'(mode_half), 33'(pump_mode));
		dropout_main <= 6'h00;
		send(8'h38, 8'h00, 8'h00, 8'h00, 4, 0);
		send(8'h36, 8'h00, 8'h00, 8'h00, 2, 2);
		rd(8'h08, {8'h00, 8'h20, 8'hA5, m}, 1'b0);
		send(8'h36, 8'h00, 8'h00, 8'h00, 4, 4);
		cmp("group off", 33'h0, 33'({main_en, flash_en}));
		rd(8'h04, 32'h4, 1'b0);
		send(8'h36, m, 8'hA5, 8'h00, 4, 4);
		resetn <= 1'b0;
		@(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(8'h08, 32'h0, 1'b0);
		give_verdict();
	end
endmodule
